/* File: hw/framer_pkg.sv */
/*
  Shared constants, field codes and carriers for the slave-side
  RTU framer. Assumes a 25 MHz clock and a byte-level receiver.
*/
// How it works
// [RULE_01] address byte 0..247, zero means broadcast
// [RULE_02] master uses 1..247 to address one slave
// [RULE_03] response opens with the query's address
// [RULE_04] function code is one byte, 1..255
// [RULE_05] unsupported function code gives error response
// [RULE_06] normal response echoes the function code
// [RULE_07] error response sends function code plus 80
// [RULE_08] read holding registers: never broadcast
// [RULE_09] single register write: addressed or broadcast
// [RULE_10] diagnostics check: never broadcast
// [RULE_11] multiple register write: addressed or broadcast
// [RULE_12] access log read: never broadcast
// [RULE_13] data field length depends on function
// [RULE_14] every message ends in two CRC bytes
// [RULE_15] CRC low byte first, then high byte
// [RULE_16] receiver recomputes CRC, mismatch is error
// [RULE_17] read reaches all holding register contents
// [RULE_18] frames bounded by 3.5 characters of silence
// [RULE_19] no answer to receive, framing or CRC error
// [RULE_20] broadcast executes but never answers
// [RULE_21] CRC init FFFF, reflected poly A001, LSB first
package framer_pkg;
  localparam logic [7:0]  ADDR_BCAST = 8'h00;
  localparam logic [7:0]  ADDR_MAX   = 8'hF7;
  localparam logic [7:0]  FC_READ    = 8'h03;
  localparam logic [7:0]  FC_WRITE1  = 8'h06;
  localparam logic [7:0]  FC_DIAG    = 8'h08;
  localparam logic [7:0]  FC_WRITEN  = 8'h10;
  localparam logic [7:0]  FC_LOG     = 8'h46;
  localparam logic [7:0]  FC_ERR_BIT = 8'h80;
  localparam logic [15:0] CRC_INIT   = 16'hFFFF;
  localparam logic [15:0] CRC_POLY   = 16'hA001;
  // one character at 19200 bit/s, 11 bits, in ns
  localparam int CLK_NS  = 40;
  localparam int CHAR_NS = 572917;
  localparam int GAP_X10 = 35;
  localparam int GAP_NS  = CHAR_NS * GAP_X10 / 10;
  localparam int GAP_CYCLES_DEF = (GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 20;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] func;
    logic       bcast;
  } hdr_type;

  typedef struct packed {
    logic    done;
    logic    exec;
    logic    drop;
    logic    respond;
    logic    err_resp;
    hdr_type hdr;
  } verdict_type;

  function automatic logic fc_known(input logic [7:0] f);
    return (f == FC_READ) || (f == FC_WRITE1) || (f == FC_DIAG)
        || (f == FC_WRITEN) || (f == FC_LOG); // [RULE_05] [RULE_17]
  endfunction

  function automatic logic fc_bcast_ok(input logic [7:0] f);
    return (f == FC_WRITE1) || (f == FC_WRITEN); // [RULE_09] [RULE_11]
  endfunction
endpackage

/* File: hw/pair_buffer.sv */
/*
  Small valid/ready FIFO, two words by default.
  Assumes both sides run on clk; out_data is read combinationally from the stored words.
*/
`timescale 1ns/1ns
`default_nettype none
module pair_buffer #(
  parameter int W     = 8, // word width
  parameter int DEPTH = 2  // number of words
) (
  input  wire logic         clk,       // clock
  input  wire logic         srst,      // sync reset, high
  input  wire logic         in_valid,  // word offered
  output logic              in_ready,  // room for a word
  input  wire logic [W-1:0] in_data,   // word in
  output logic              out_valid, // word held
  input  wire logic         out_ready, // sink takes word
  output logic [W-1:0]      out_data   // oldest word
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0]   FULL  = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LASTP = AW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
  } buf_type;

  buf_type b_r;
  buf_type b_nxt;
  logic    push;
  logic    pop;

  assign in_ready  = b_r.cnt != FULL;
  assign out_valid = b_r.cnt != '0;
  assign out_data  = b_r.mem[b_r.rp];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    b_nxt = b_r;
    if (push) begin
      b_nxt.mem[b_r.wp] = in_data;
      b_nxt.wp = (b_r.wp == LASTP) ? '0 : AW'(b_r.wp + 1'b1);
    end
    if (pop) begin
      b_nxt.rp = (b_r.rp == LASTP) ? '0 : AW'(b_r.rp + 1'b1);
    end
    if (push && !pop) begin
      b_nxt.cnt = (AW + 1)'(b_r.cnt + 1'b1);
    end else if (pop && !push) begin
      b_nxt.cnt = (AW + 1)'(b_r.cnt - 1'b1);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      b_r <= '0;
    end else begin
      b_r <= b_nxt;
    end
  end
endmodule
`default_nettype wire

/* File: hw/modbus_rtu_slave_framer.sv */
/*
  Slave-side RTU framer: finds frames by line silence, checks
  station, function code and CRC, streams the data field and
  queues the response header bytes for the transmitter.
  Assumes a byte receiver on clk that pulses rx_valid once per
  character, and a transmitter that drains tx_valid/tx_data.
*/
`timescale 1ns/1ns
`default_nettype none
module modbus_rtu_slave_framer #(
  parameter int GAP_CYCLES = framer_pkg::GAP_CYCLES_DEF // silence
) (
  input  wire logic               clk,      // 25 MHz clock
  input  wire logic               srst,     // sync reset, high
  input  wire logic [7:0]         station_number_setting, // own id
  input  wire logic               rx_valid, // byte received
  input  wire logic [7:0]         rx_data,  // received byte
  input  wire logic               rx_err,   // parity or framing
  output logic                    pay_valid, // data field byte
  output logic [7:0]              pay_data,  // data byte
  output framer_pkg::verdict_type verdict,   // end-of-frame result
  output logic                    tx_valid,  // header byte ready
  output logic [7:0]              tx_data,   // header byte
  input  wire logic               tx_ready   // transmitter takes
);
  import framer_pkg::*;

  localparam logic [CNT_W-1:0] GAP_LAST = CNT_W'(GAP_CYCLES - 1);

  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_RECV = 4'h2,
    S_ADDR = 4'h4,
    S_FUNC = 4'h8
  } fsm_type;

  typedef struct packed {
    fsm_type          fsm;
    logic [CNT_W-1:0] cnt;
    logic             armed;
    logic [1:0]       held;
    logic [7:0]       w_old;
    logic [7:0]       w_new;
    logic [1:0]       nout;
    logic [15:0]      crc;
    logic             bad;
    logic             err;
    logic             pay_v;
    logic [7:0]       pay_d;
    verdict_type      vd;
  } st_type;

  localparam st_type ST_RESET = '{fsm: S_IDLE, default: '0};

  st_type     st_r;
  st_type     st_nxt;
  logic       bc;
  logic       mine;
  logic       len_ok;
  logic       crc_ok;
  logic       good;
  logic       take;
  logic       known;
  logic       exec;
  logic       quiet;
  logic       frame_end;
  logic       push_v;
  logic       push_rdy;
  logic [7:0] push_d;

  function automatic logic [15:0] crc_step(
    input logic [15:0] c,
    input logic [7:0]  b
  );
    logic [15:0] x;
    x = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1); // [RULE_21]
    end
    return x;
  endfunction

  // verdict terms, valid in the cycle the closing gap completes
  assign bc = st_r.vd.hdr.addr == ADDR_BCAST; // [RULE_01]
  assign mine = (st_r.vd.hdr.addr == station_number_setting)
              & (station_number_setting != ADDR_BCAST)
              & (st_r.vd.hdr.addr <= ADDR_MAX); // [RULE_01]
  // shorter than address, function and two check bytes: drop
  assign len_ok = (st_r.held == 2'h2) & (st_r.nout == 2'h2);
  // older window byte is the low half of the check word
  assign crc_ok = st_r.crc == {st_r.w_new, st_r.w_old}; // [RULE_15]
  assign good = len_ok & crc_ok & !st_r.bad; // [RULE_16] [RULE_19]
  assign take = good & (bc | mine);
  assign known = fc_known(st_r.vd.hdr.func); // [RULE_04] [RULE_05]
  // reads, diagnostics and log reads are not run on broadcast
  assign exec = take & known
              & (!bc | fc_bcast_ok(st_r.vd.hdr.func)); // [RULE_08] [RULE_10] [RULE_12]
  assign quiet = !rx_valid & (st_r.cnt == GAP_LAST); // [RULE_18]
  assign frame_end = (st_r.fsm == S_RECV) & quiet;

  always_comb begin
    st_nxt = st_r;
    st_nxt.vd.done = 1'b0;
    st_nxt.vd.exec = 1'b0;
    st_nxt.vd.drop = 1'b0;
    st_nxt.vd.respond = 1'b0;
    st_nxt.vd.err_resp = 1'b0;
    st_nxt.pay_v = 1'b0;
    push_v = 1'b0;
    push_d = st_r.vd.hdr.addr;
    if (rx_valid) begin
      st_nxt.cnt = '0;
    end else if (st_r.cnt != GAP_LAST) begin
      st_nxt.cnt = CNT_W'(st_r.cnt + 1'b1);
    end
    unique case (st_r.fsm)
      S_IDLE: begin
        if (rx_valid) begin
          st_nxt.fsm = S_RECV;
          st_nxt.w_new = rx_data;
          st_nxt.held = 2'h1;
          st_nxt.nout = 2'h0;
          st_nxt.crc = CRC_INIT; // [RULE_21]
          st_nxt.vd.hdr = '0;
          // no full gap before the first byte: not a frame start
          st_nxt.bad = rx_err | !st_r.armed; // [RULE_18] [RULE_19]
        end else if (quiet) begin
          st_nxt.armed = 1'b1;
        end
      end
      S_RECV: begin
        if (rx_valid) begin
          st_nxt.bad = st_r.bad | rx_err; // [RULE_19]
          // last two bytes stay held back: they may be the check
          st_nxt.w_old = st_r.w_new; // [RULE_14]
          st_nxt.w_new = rx_data;
          if (st_r.held == 2'h2) begin
            st_nxt.crc = crc_step(st_r.crc, st_r.w_old); // [RULE_16]
            unique case (st_r.nout)
              2'h0: begin
                st_nxt.vd.hdr.addr = st_r.w_old;
                st_nxt.nout = 2'h1;
              end
              2'h1: begin
                st_nxt.vd.hdr.func = st_r.w_old;
                st_nxt.nout = 2'h2;
              end
              default: begin
                st_nxt.pay_v = 1'b1; // [RULE_13]
                st_nxt.pay_d = st_r.w_old;
              end
            endcase
          end else begin
            st_nxt.held = 2'(st_r.held + 1'b1);
          end
        end else if (quiet) begin
          st_nxt.armed = 1'b1;
          st_nxt.vd.done = 1'b1;
          st_nxt.vd.hdr.bcast = bc;
          st_nxt.vd.exec = exec; // [RULE_09] [RULE_11]
          st_nxt.vd.drop = !take; // [RULE_19]
          st_nxt.vd.respond = take & !bc; // [RULE_20]
          st_nxt.vd.err_resp = take & !bc & !known; // [RULE_05]
          st_nxt.err = take & !bc & !known;
          st_nxt.fsm = (take & !bc) ? S_ADDR : S_IDLE; // [RULE_20]
        end
      end
      S_ADDR: begin
        push_v = 1'b1;
        push_d = st_r.vd.hdr.addr; // [RULE_03]
        if (push_rdy) begin
          st_nxt.fsm = S_FUNC;
        end
        // half duplex: talk-over means the next frame start is unsure
        if (rx_valid) begin
          st_nxt.armed = 1'b0;
        end
      end
      S_FUNC: begin
        push_v = 1'b1;
        if (st_r.err) begin
          push_d = st_r.vd.hdr.func | FC_ERR_BIT; // [RULE_07]
        end else begin
          push_d = st_r.vd.hdr.func; // [RULE_06]
        end
        if (push_rdy) begin
          st_nxt.fsm = S_IDLE;
        end
        if (rx_valid) begin
          st_nxt.armed = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= ST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pay_valid = st_r.pay_v;
  assign pay_data  = st_r.pay_d;
  assign verdict   = st_r.vd;

  // header bytes wait here so a slow transmitter loses nothing
  pair_buffer #(
    .W     (8),
    .DEPTH (2)
  ) u_txq (
    .clk       (clk),
    .srst      (srst),
    .in_valid  (push_v),
    .in_ready  (push_rdy),
    .in_data   (push_d),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (tx_data)
  );

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  station_match_a: assert property ( // [RULE_01]
    verdict.respond |->
      (verdict.hdr.addr == $past(station_number_setting))
      && (verdict.hdr.addr != ADDR_BCAST)
      && (verdict.hdr.addr <= ADDR_MAX)
  ) else $error("response to a foreign or invalid address");

  resp_addr_a: assert property ( // [RULE_03]
    verdict.respond |->
      (st_r.fsm == S_ADDR) && push_v
      && (push_d == verdict.hdr.addr)
  ) else $error("first response byte is not the address");

  fc_echo_a: assert property ( // [RULE_06]
    (st_r.fsm == S_FUNC) && !st_r.err |->
      push_v && (push_d == st_r.vd.hdr.func)
  ) else $error("normal response lost the function code");

  fc_err_a: assert property ( // [RULE_07]
    (st_r.fsm == S_FUNC) && st_r.err |->
      push_v && (push_d == (st_r.vd.hdr.func | FC_ERR_BIT))
  ) else $error("error response lacks the top bit");

  bad_fc_a: assert property ( // [RULE_05]
    verdict.respond && !fc_known(verdict.hdr.func) |->
      verdict.err_resp && !verdict.exec
  ) else $error("unsupported code not answered as error");

  good_fc_a: assert property ( // [RULE_04]
    verdict.respond && fc_known(verdict.hdr.func) |->
      !verdict.err_resp && verdict.exec
  ) else $error("supported code refused");

  // a new frame may start right after done, so only ADDR is ruled out
  bcast_quiet_a: assert property ( // [RULE_20]
    verdict.done && verdict.hdr.bcast |->
      !verdict.respond ##1 (st_r.fsm != S_ADDR) && !push_v
  ) else $error("broadcast produced a response");

  bcast_write_a: assert property ( // [RULE_09]
    verdict.done && verdict.hdr.bcast && !verdict.drop
      && fc_bcast_ok(verdict.hdr.func) |-> verdict.exec
  ) else $error("broadcast write not executed");

  bcast_read_a: assert property ( // [RULE_08]
    verdict.exec && verdict.hdr.bcast |->
      fc_bcast_ok(verdict.hdr.func)
  ) else $error("read-type code executed on broadcast");

  crc_drop_a: assert property ( // [RULE_16]
    frame_end && !crc_ok |=>
      verdict.done && verdict.drop && !verdict.respond
      && !verdict.exec ##1 !push_v
  ) else $error("CRC mismatch not dropped silently");

  gap_end_a: assert property ( // [RULE_18]
    $rose(verdict.done) |->
      $past(!rx_valid) && ($past(st_r.cnt) == GAP_LAST)
  ) else $error("frame closed before the full silence");

  crc_init_a: assert property ( // [RULE_21]
    $rose(st_r.fsm == S_RECV) |-> (st_r.crc == CRC_INIT)
  ) else $error("CRC not seeded at frame start");

  hdr_bytes_a: assert property ( // [RULE_03]
    $rose(st_r.fsm == S_ADDR) |->
      ##[1:1000] (st_r.fsm == S_FUNC)
  ) else $error("address byte never taken by the queue");

  normal_c: cover property (
    verdict.respond && !verdict.err_resp
  );

  error_c: cover property (
    verdict.respond && verdict.err_resp
  );

  bcast_c: cover property (
    verdict.exec && verdict.hdr.bcast
  );

  stall_c: cover property (
    push_v && !push_rdy
  );
endmodule
`default_nettype wire

/* File: verification/rtu_master.sv */
/*
  Master-side model: sends query bytes back to back with the check
  word appended, drains header bytes with random stalls.
  Assumes the framer samples its inputs on the rising edge of clk.
*/
`timescale 1ns/1ns
`default_nettype none
module rtu_master
  import framer_pkg::*;
(
  input  wire logic  clk,      // framer clock
  output logic       rx_valid, // byte strobe
  output logic [7:0] rx_data,  // byte
  output logic       rx_err,   // line error flag
  input  wire logic  tx_valid, // header byte offered
  output logic       tx_ready  // header byte taken
);
  logic [15:0] s = 16'h0020;
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    rx_err   = 1'b0;
    tx_ready = 1'b0;
  end
  // stalls about half the time so the header queue backs up
  always @(posedge clk) begin
    s <= {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    tx_ready <= #2 s[3];
  end
  task automatic send(input logic [7:0] b[6], input int n,
                      input logic cb, input int eat);
    logic [15:0] c;
    logic [7:0]  x;
    int          i;
    int          j;
    c = CRC_INIT;
    for (i = 0; i < n + 2; i++) begin
      if (i < n) begin
        x = b[i];
        c = c ^ {8'h00, x};
        for (j = 0; j < 8; j++) begin
          c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
        end
      end else begin
        x = (i == n) ? c[7:0] ^ {7'h00, cb} : c[15:8];
      end
      @(posedge clk);
      #2;
      rx_valid = 1'b1;
      rx_data  = x;
      rx_err   = (i == eat);
    end
    @(posedge clk);
    #2;
    rx_valid = 1'b0;
    rx_data  = ~x; // released line shows no stale byte
    rx_err   = 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: verification/tb_modbus_rtu_slave_framer.sv */
/*
  Bench for the slave framer: corner and random queries through the
  master model; checks verdict, data stream and response header.
  Assumes rtu_master.sv and the framer package are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_modbus_rtu_slave_framer;
  import framer_pkg::*;
  localparam int GAP = 20;
  logic        clk  = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  stn  = 8'h11;
  logic        rx_valid, rx_err, pay_valid, tx_valid, tx_ready;
  logic [7:0]  rx_data, pay_data, tx_data, x, y, a, f;
  verdict_type verdict, v;
  logic        got = 1'b0;
  logic [7:0]  payq[$], txq[$];
  logic [7:0]  codes[7] = '{8'h03, 8'h06, 8'h08, 8'h10, 8'h46, 8'h00, 8'hFF};
  int          bad_count = 0, checked = 0, cyc = 0, i, n;
  logic [15:0] r = 16'h0020;
  always #20 clk = ~clk;
  modbus_rtu_slave_framer #(.GAP_CYCLES(GAP)) DUT (
    .clk(clk), .srst(srst), .station_number_setting(stn),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_err(rx_err),
    .pay_valid(pay_valid), .pay_data(pay_data), .verdict(verdict),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
  rtu_master m (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_err(rx_err), .tx_valid(tx_valid), .tx_ready(tx_ready));
  always @(posedge clk) begin
    if (pay_valid === 1'b1) payq.push_back(pay_data);
    if ((tx_valid & tx_ready) === 1'b1) txq.push_back(tx_data);
    if (verdict.done === 1'b1) begin
      v = verdict;
      got = 1'b1;
    end
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      end_sim();
    end
  end
  task end_sim();
    if (bad_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task cmp1(input string nm, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s exp %b got %b", nm, e, g);
    end
  endtask
  task cmp8(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  function automatic logic [7:0] roll();
    r = {r[14:0], r[15] ^ r[13] ^ r[12] ^ r[10]};
    return r[7:0] ^ r[15:8];
  endfunction
  // {exec, drop, respond, err_resp, bcast}
  function automatic logic [4:0] expect_v(input logic [7:0] a, f, s,
                                          input int n, input logic bad);
    logic known, bok;
    known = f == FC_READ || f == FC_WRITE1 || f == FC_DIAG
         || f == FC_WRITEN || f == FC_LOG;
    bok = f == FC_WRITE1 || f == FC_WRITEN;
    if (bad || n < 2 || a > ADDR_MAX || (a != ADDR_BCAST && a != s))
      return 5'b01000;
    if (a == ADDR_BCAST) return {known && bok, 3'b000, 1'b1};
    return {known, 1'b0, 1'b1, !known, 1'b0};
  endfunction
  task automatic run(input logic [7:0] a, f, input int n,
                     input logic cb, input int eat);
    logic [7:0] b[6];
    logic [4:0] e;
    int         k;
    b[0] = a;
    b[1] = f;
    for (k = 2; k < 6; k++) b[k] = roll();
    e = expect_v(a, f, stn, n, cb || eat >= 0);
    payq.delete();
    txq.delete();
    got = 1'b0;
    m.send(b, n, cb, eat);
    for (k = 0; k < GAP + 10 && !got; k++) begin
      @(posedge clk);
      #1;
    end
    cmp1("done", 1'b1, got);
    cmp1("drop", e[3], v.drop);
    cmp1("exec", e[4], v.exec);
    cmp1("respond", e[2], v.respond);
    cmp1("err_resp", e[1], v.err_resp);
    if (!e[3]) begin
      cmp1("bcast", e[0], v.hdr.bcast);
      cmp8("addr", a, v.hdr.addr);
      cmp8("func", f, v.hdr.func);
      cmp8("pay_count", 8'(n - 2), 8'(payq.size()));
      for (k = 2; k < n; k++) begin
        cmp8("pay", b[k], payq[k-2]);
      end
    end
    repeat (3) @(posedge clk);
    for (k = 0; k < 60 && tx_valid !== 1'b0; k++) @(posedge clk);
    #1;
    cmp8("tx_count", e[2] ? 8'h02 : 8'h00, 8'(txq.size()));
    if (e[2]) begin
      cmp8("tx_addr", a, txq[0]);
      x = f | (e[1] ? FC_ERR_BIT : 8'h00);
      cmp8("tx_func", x, txq[1]);
    end
    repeat (GAP + 2) @(posedge clk);
    #2;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    #2;
    srst = 1'b0;
    repeat (GAP + 2) @(posedge clk);
    #2;
    for (i = 0; i < 7; i++) begin
      run(stn, codes[i], 6, 1'b0, -1);
      run(ADDR_BCAST, codes[i], 6, 1'b0, -1);
    end
    run(stn, FC_READ, 6, 1'b1, -1);
    run(stn, FC_DIAG, 4, 1'b0, 3);
    run(stn, FC_LOG, 1, 1'b0, -1);
    run(8'hF8, FC_READ, 6, 1'b0, -1);
    run(stn + 8'h01, FC_WRITE1, 2, 1'b0, -1);
    stn = 8'h00;
    run(ADDR_BCAST, FC_WRITEN, 6, 1'b0, -1);
    run(8'h01, FC_READ, 6, 1'b0, -1);
    stn = ADDR_MAX;
    run(ADDR_MAX, FC_WRITE1, 6, 1'b0, -1);
    // random mix of addresses, codes, lengths and line faults
    for (i = 0; i < 30; i++) begin
      x = roll();
      stn = (x % 8'd247) + 8'd1;
      x = roll();
      y = roll();
      a = (x[1:0] == 2'b00) ? ADDR_BCAST : (x[1:0] == 2'b01) ? x : stn;
      f = y[3] ? y : codes[y % 8'd7];
      n = (x[7:6] == 2'b11) ? 1 : 2 + x % 8'd5;
      run(a, f, n, y[7:5] == 3'b000,
          (y[2:0] == 3'b000) ? int'(y % 8'd3) : -1);
    end
    end_sim();
  end
endmodule
`default_nettype wire
